// file: rtl/rsb_top.sv
// Reset entry, strap capture and boot chip-select defaults.
// Assumes reset_in_n, lock status and straps come from pins and are
// synchronised here; the clock generator itself lives outside.
//
// Contract
// - Reset input forces reset exception state.
// - In reset, negate request/driven, float bus.
// - Reset output asserts with reset input.
// - Reset output held until clock relocks.
// - Bus clock is core divided by ratio.
// - D7 latches boot auto-ack, 15 waits.
// - D6:5 latch boot port width.
// - D4 latches pin-assignment default.
// - D3:2 latch clock range code.
// - D1:0 latch bus clock ratio.
// - Reset clears selects; only boot valid.
// - Boot select matches any address.
// - Select changes only on bus clock fall; code also clears it at reset entry, fall or not.
// - Read strobe only when select matches.
`timescale 1ns/1ns
module rsb_top
  import rsb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reset_in_n,
  input  wire logic        pll_locked,
  input  wire logic [7:0]  data_in,
  input  wire logic        xfer_req,
  input  wire logic        xfer_read,
  output logic             reset_out_n,
  output logic             in_reset,
  output logic             bus_request_n,
  output logic             bus_driven_n,
  output logic             bus_oe,
  output logic             auto_ack_enable,
  output logic [3:0]       auto_ack_waits,
  output logic [1:0]       port_width,
  output logic             pin_assignment,
  output logic [1:0]       pll_range_strap,
  output logic             range_reserved,
  output logic [1:0]       bus_ratio,
  output logic             ratio_reserved,
  output logic             boot_select_valid,
  output logic             bus_clock_out,
  output logic             boot_select_n,
  output logic             read_enable_n
);
  import rsb_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Two stages per pin; only the second stage is read by logic.
  logic       rin_s1_r, rin_s2_r, lock_s1_r, lock_s2_r;
  logic [7:0] dat_s1_r, dat_s2_r;
  logic       rin_s1_nxt, rin_s2_nxt, lock_s1_nxt, lock_s2_nxt;
  logic [7:0] dat_s1_nxt, dat_s2_nxt;

  always_comb
  begin
    rin_s1_nxt  = reset_in_n;
    rin_s2_nxt  = rin_s1_r;
    lock_s1_nxt = pll_locked;
    lock_s2_nxt = lock_s1_r;
    dat_s1_nxt  = data_in;
    dat_s2_nxt  = dat_s1_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rin_s1_r  <= 1'b0;
      rin_s2_r  <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      dat_s1_r  <= STRAP_RST;
      dat_s2_r  <= STRAP_RST;
    end
    else
    begin
      rin_s1_r  <= rin_s1_nxt;
      rin_s2_r  <= rin_s2_nxt;
      lock_s1_r <= lock_s1_nxt;
      lock_s2_r <= lock_s2_nxt;
      dat_s1_r  <= dat_s1_nxt;
      dat_s2_r  <= dat_s2_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------------
  // The lock input alone cannot be trusted right after reset entry, as
  // the clock generator takes a while to drop lock; a minimum hold time
  // covers that window.
  rsb_state_t  state_r, state_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [7:0]  strap_r, strap_nxt;
  logic        rin_prev_r, rin_prev_nxt;
  logic        rout_r, rout_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    hold_nxt     = hold_r;
    strap_nxt    = strap_r;
    rin_prev_nxt = rin_s2_r;
    rout_nxt     = rout_r;
    case (state_r)
      ST_RUN:
      begin
        if (!rin_s2_r)
        begin
          state_nxt = ST_RESET;
          rout_nxt  = 1'b0;
        end
      end
      ST_RESET:
      begin
        rout_nxt = 1'b0;
        hold_nxt = 16'h0000;
        // Capture straps exactly on the reset input's rising edge.
        if (rin_s2_r && !rin_prev_r)
        begin
          strap_nxt = dat_s2_r;
          state_nxt = ST_RELOCK;
        end
      end
      ST_RELOCK:
      begin
        if (!rin_s2_r)
          state_nxt = ST_RESET;
        else if (hold_r >= 16'(LOCK_CYCLES) && lock_s2_r)
        begin
          rout_nxt  = 1'b1;
          state_nxt = ST_RUN;
        end
        else if (hold_r < 16'(LOCK_CYCLES))
          hold_nxt = hold_r + 16'h0001;
      end
      default:
        state_nxt = ST_RESET;
    endcase
  end

  // Reset comes up in the reset state so the straps get a clean capture.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r    <= ST_RESET;
      hold_r     <= 16'h0000;
      strap_r    <= STRAP_RST;
      rin_prev_r <= 1'b0;
      rout_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      hold_r     <= hold_nxt;
      strap_r    <= strap_nxt;
      rin_prev_r <= rin_prev_nxt;
      rout_r     <= rout_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Strap decode
  // ------------------------------------------------------------------
  // Port width: 1x always means 16-bit regardless of the low bit.
  function automatic logic [1:0] pw_decode(input logic [1:0] s);
    pw_decode = s[1] ? PW_16 : (s[0] ? PW_8 : PW_32);
  endfunction

  // Bus clock divide for a ratio code; the reserved code runs as 1/4.
  function automatic logic [2:0] div_decode(input logic [1:0] r);
    if (r == RATIO_HALF)
      div_decode = DIV_HALF;
    else if (r == RATIO_THIRD)
      div_decode = DIV_THIRD;
    else
      div_decode = DIV_QUARTER;
  endfunction

  // ------------------------------------------------------------------
  // Bus clock divider and boot select
  // ------------------------------------------------------------------
  // The divider is held at zero in reset so the bus clock restarts
  // cleanly with the new ratio.
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic       bclk_r, bclk_nxt;
  logic       bclk_fall;
  logic       cs_r, cs_nxt;
  logic       oe_r, oe_nxt;
  logic       active;
  logic [2:0] div_n;

  always_comb
  begin
    active      = (state_r == ST_RUN);
    div_n       = div_decode(strap_r[STRAP_RATIO_HI:STRAP_RATIO_LO]);
    div_cnt_nxt = 3'h0;
    bclk_nxt    = 1'b0;
    if (active)
    begin
      div_cnt_nxt = (div_cnt_r == div_n - 3'h1) ? 3'h0
                                                : div_cnt_r + 3'h1;
      bclk_nxt    = (div_cnt_nxt < (div_n >> 1));
    end
    bclk_fall = bclk_r && !bclk_nxt;
    cs_nxt    = cs_r;
    oe_nxt    = oe_r;
    if (!active)
    begin
      cs_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (bclk_fall)
    begin
      cs_nxt = xfer_req;
      oe_nxt = xfer_req && xfer_read;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_cnt_r <= 3'h0;
      bclk_r    <= 1'b0;
      cs_r      <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      bclk_r    <= bclk_nxt;
      cs_r      <= cs_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  // All outputs are registered once more so each leaves from a flop.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reset_out_n       <= 1'b0;
      in_reset          <= 1'b1;
      bus_request_n     <= 1'b1;
      bus_driven_n      <= 1'b1;
      bus_oe            <= 1'b0;
      auto_ack_enable   <= 1'b0;
      auto_ack_waits    <= 4'h0;
      port_width        <= PW_32;
      pin_assignment    <= 1'b0;
      pll_range_strap   <= 2'h0;
      range_reserved    <= 1'b0;
      bus_ratio         <= RATIO_QUARTER;
      ratio_reserved    <= 1'b0;
      boot_select_valid <= 1'b0;
      bus_clock_out     <= 1'b0;
      boot_select_n     <= 1'b1;
      read_enable_n     <= 1'b1;
    end
    else
    begin
      reset_out_n     <= rout_r;
      in_reset        <= !active;
      bus_request_n   <= 1'b1;
      bus_driven_n    <= active ? 1'b0 : 1'b1;
      bus_oe          <= active;
      auto_ack_enable <= strap_r[STRAP_AA_BIT];
      auto_ack_waits  <= strap_r[STRAP_AA_BIT] ? AA_WAIT_STATES
                                               : 4'h0;
      port_width      <= pw_decode(
                           strap_r[STRAP_PS_HI:STRAP_PS_LO]);
      pin_assignment  <= strap_r[STRAP_PAR_BIT];
      pll_range_strap <= strap_r[STRAP_RANGE_HI:STRAP_RANGE_LO];
      range_reserved  <= (strap_r[STRAP_RANGE_HI:STRAP_RANGE_LO]
                          == RANGE_RSVD);
      bus_ratio       <= strap_r[STRAP_RATIO_HI:STRAP_RATIO_LO];
      ratio_reserved  <= (strap_r[STRAP_RATIO_HI:STRAP_RATIO_LO]
                          == RATIO_RSVD);
      boot_select_valid <= (state_r != ST_RESET);
      bus_clock_out   <= bclk_r;
      boot_select_n   <= !cs_r;
      read_enable_n   <= !oe_r;
    end
  end

endmodule

// file: inc/rsb_pkg.sv
// Package for the reset strap boot configuration block.
// Assumes one 250 MHz system clock and a synchronous active-low reset.
package rsb_pkg;

  // ----------------------------------------------------------------
  // Strap bit positions on the low data pins
  // ----------------------------------------------------------------
  localparam int STRAP_AA_BIT    = 7;
  localparam int STRAP_PS_HI     = 6;
  localparam int STRAP_PS_LO     = 5;
  localparam int STRAP_PAR_BIT   = 4;
  localparam int STRAP_RANGE_HI  = 3;
  localparam int STRAP_RANGE_LO  = 2;
  localparam int STRAP_RATIO_HI  = 1;
  localparam int STRAP_RATIO_LO  = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PW_32         = 2'h0;
  localparam logic [1:0] PW_8          = 2'h1;
  localparam logic [1:0] PW_16         = 2'h2;
  localparam logic [1:0] RATIO_QUARTER = 2'h0;
  localparam logic [1:0] RATIO_RSVD    = 2'h1;
  localparam logic [1:0] RATIO_HALF    = 2'h2;
  localparam logic [1:0] RATIO_THIRD   = 2'h3;
  localparam logic [1:0] RANGE_RSVD    = 2'h3;
  localparam logic [3:0] AA_WAIT_STATES = 4'hf;
  localparam logic [7:0] STRAP_RST     = 8'h00;

  // Core cycles per bus clock for each ratio.
  localparam logic [2:0] DIV_HALF      = 3'h2;
  localparam logic [2:0] DIV_THIRD     = 3'h3;
  localparam logic [2:0] DIV_QUARTER   = 3'h4;

  // Lock settling time after the reset input rises, in ns.
  localparam int LOCK_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCK_CYCLES   = LOCK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_RUN, ST_RESET, ST_RELOCK} rsb_state_t;

endpackage

// file: test/rsb_monitor.sv
// Port checker for the reset strap block.
// Assumes binding into rsb_top; one clock, sync active-low reset.
`timescale 1ns/1ns
module rsb_monitor
  import rsb_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       reset_in_n,
  input wire logic       pll_locked,
  input wire logic       reset_out_n,
  input wire logic       in_reset,
  input wire logic       bus_request_n,
  input wire logic       bus_driven_n,
  input wire logic       bus_oe,
  input wire logic       auto_ack_enable,
  input wire logic [3:0] auto_ack_waits,
  input wire logic [1:0] port_width,
  input wire logic       pin_assignment,
  input wire logic [1:0] pll_range_strap,
  input wire logic       range_reserved,
  input wire logic [1:0] bus_ratio,
  input wire logic       ratio_reserved,
  input wire logic       bus_clock_out,
  input wire logic       boot_select_n,
  input wire logic       read_enable_n
);
  // ------
  // Properties, all on sys_clk.
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_entry;
    !reset_in_n |-> ##[1:4] (in_reset && !reset_out_n);
  endproperty
  a_entry: assert property (p_entry) else $error("late entry");
  property p_quiet;
    in_reset |-> bus_driven_n && bus_request_n && !bus_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus not quiet");
  property p_hold; !reset_out_n && !pll_locked |=> !reset_out_n; endproperty
  a_hold: assert property (p_hold) else $error("early reset exit");
  property p_waits;
    auto_ack_waits == (auto_ack_enable ? AA_WAIT_STATES : 4'h0);
  endproperty
  a_waits: assert property (p_waits) else $error("bad wait count");
  property p_rsvd;
    range_reserved == (pll_range_strap == RANGE_RSVD) &&
    ratio_reserved == (bus_ratio == RATIO_RSVD);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bad rsvd");
  // A run cycle preceded by a run cycle must never see a strap move.
  property p_keep;
    !in_reset && $past(!in_reset) |->
      $stable({auto_ack_enable, port_width, pin_assignment,
               pll_range_strap, bus_ratio});
  endproperty
  a_keep: assert property (p_keep) else $error("strap moved");
  property p_half;
    !in_reset && bus_ratio == RATIO_HALF && $rose(bus_clock_out)
      |=> $fell(bus_clock_out);
  endproperty
  a_half: assert property (p_half) else $error("bad half rate");
  property p_oe; !read_enable_n |-> !boot_select_n; endproperty
  a_oe: assert property (p_oe) else $error("strobe, no select");
  property p_sel_rst; in_reset |-> boot_select_n && read_enable_n; endproperty
  a_sel_rst: assert property (p_sel_rst) else $error("select in reset");
  // Select and read strobe leave the block on the same edge as the
  // bus clock fall, so outside reset they move at the pins only with that fall.
  property p_edge;
    ($changed(boot_select_n) || $changed(read_enable_n)) &&
      !in_reset && !$past(in_reset) |->
      $fell(bus_clock_out);
  endproperty
  a_edge: assert property (p_edge) else $error("select off edge");
  c_relock: cover property ($rose(reset_out_n));
  c_read: cover property ($fell(read_enable_n));
  c_third: cover property (!in_reset && bus_ratio == RATIO_THIRD);
endmodule
bind rsb_top rsb_monitor i_rsb_monitor (.*);

// file: test/rsb_board.sv
// Board model: reset source, strap drivers and clock-generator lock.
// Assumes hold_n and strap come from the bench on falling edges.
`timescale 1ns/1ns
module rsb_board
  import rsb_pkg::*;
#(
  parameter int LOCK_DLY = 400
)
(
  input  wire logic       sys_clk,
  input  wire logic       hold_n,
  input  wire logic [7:0] strap,
  output logic            reset_in_n,
  output logic            pll_locked,
  output logic [7:0]      data_in
);
  int cnt = 0;
  int post = 0;
  initial
  begin
    reset_in_n = 1'b0;
    pll_locked = 1'b0;
    data_in = 8'h00;
  end
  // Lock is lost at reset entry. Straps stay a while past the rise,
  // then the pins carry traffic, modelled as a pattern that flips.
  always @(negedge sys_clk)
  begin
    reset_in_n <= hold_n;
    cnt <= (!hold_n && reset_in_n) ? 0 : cnt + 1;
    pll_locked <= (cnt >= LOCK_DLY);
    post <= hold_n ? post + 1 : 0;
    if (!hold_n || post < 8)
      data_in <= strap;
    else
      data_in <= ~data_in;
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the reset strap block and its board model.
// Assumes package constants; stimulus changes on falling edges.
`timescale 1ns/1ns
module testbench;
  import rsb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold_n = 1'b0;
  logic [7:0] strap = 8'h00;
  logic xfer_req = 1'b0;
  logic xfer_read = 1'b0;
  logic reset_in_n, pll_locked, reset_out_n, in_reset, bus_request_n;
  logic bus_driven_n, bus_oe, auto_ack_enable, pin_assignment;
  logic range_reserved, ratio_reserved, boot_select_valid;
  logic bus_clock_out, boot_select_n, read_enable_n, bclk_q;
  logic [3:0] auto_ack_waits;
  logic [1:0] port_width, pll_range_strap, bus_ratio;
  logic [7:0] data_in;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int last_rise = 0;
  int per = 0;
  wire [7:0] quiet_v = {boot_select_valid, in_reset, reset_out_n, bus_oe,
    bus_driven_n, bus_request_n, boot_select_n, read_enable_n};
  wire [7:0] strap_v = {auto_ack_enable, port_width, pin_assignment,
    pll_range_strap, bus_ratio};
  wire [7:0] flag_v = {1'b0, auto_ack_waits, range_reserved,
    ratio_reserved, boot_select_valid};
  rsb_top i_rsb_top (.*);
  rsb_board i_rsb_board (.*);
  always #2 sys_clk = ~sys_clk;
  // Bus clock period in core cycles, and a ceiling against hangs.
  always @(negedge sys_clk)
  begin
    cyc <= cyc + 1;
    bclk_q <= bus_clock_out;
    if (bus_clock_out === 1'b1 && bclk_q === 1'b0)
    begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 8000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One boot-select access; the select must come at any address.
  // The request is launched while the bus clock is high, as board
  // logic timed against the bus clock would do.
  task automatic xfer(input logic rd);
    int k;
    for (k = 0; k < 8 && bus_clock_out !== 1'b1; k++)
      @(negedge sys_clk);
    xfer_read = rd;
    xfer_req = 1'b1;
    for (k = 0; k < 16 && boot_select_n !== 1'b0; k++)
      @(negedge sys_clk);
    check("select", {7'h00, boot_select_n}, 8'h00);
    check("strobe", {7'h00, read_enable_n}, {7'h00, ~rd});
    xfer_req = 1'b0;
    repeat (12) @(negedge sys_clk);
    check("idle", {6'h00, boot_select_n, read_enable_n}, 8'h03);
  endtask
  // Reset with one strap set, relock, then check the captured values.
  task automatic boot(input logic [7:0] s);
    int k;
    logic [7:0] es;
    logic [7:0] ef;
    logic [2:0] dv;
    es = {s[7], s[6] ? PW_16 : (s[5] ? PW_8 : PW_32), s[4], s[3:0]};
    ef = {1'b0, s[7] ? AA_WAIT_STATES : 4'h0, s[3:2] == RANGE_RSVD,
          s[1:0] == RATIO_RSVD, 1'b1};
    dv = (s[1:0] == RATIO_HALF) ? DIV_HALF :
         ((s[1:0] == RATIO_THIRD) ? DIV_THIRD : DIV_QUARTER);
    strap = s;
    hold_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    check("quiet", quiet_v, 8'h4f);
    hold_n = 1'b1;
    for (k = 0; k < 600 && pll_locked !== 1'b1; k++)
      @(negedge sys_clk);
    check("held", {7'h00, reset_out_n}, 8'h00);
    for (k = 0; k < 8 && reset_out_n !== 1'b1; k++)
      @(negedge sys_clk);
    check("relock", {7'h00, reset_out_n}, 8'h01);
    repeat (24) @(negedge sys_clk);
    check("straps", strap_v, es);
    check("flags", flag_v, ef);
    check("period", 8'(per), {5'h00, dv});
    check("run", {6'h00, in_reset, bus_driven_n}, 8'h00);
    xfer(1'b1);
    xfer(1'b0);
  endtask
  // Every port width, range and ratio code; the first boot from power-on reset, the rest reset from run.
  initial
  begin
    logic [7:0] tbl [4] = '{8'h00, 8'ha6, 8'hdb, 8'h7d};
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (tbl[i])
      boot(tbl[i]);
    end_of_test();
  end
endmodule
